// ---- verilog/fps_sequencer.sv ----
// Flash page program sequencer with APB registers
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/10ps
// What this block does
// - Launch needs key writes with upper nibble 5 then A
// - Second key write runs the operation chosen by target select
// - Instruction cycle between key writes or wrong second key is an error; other writes only disarm
// - Target select at the last key write picks the destination
// - Security byte bits may rise to one only after full erase
// - Buffer takes zero to 128 bytes in any order by pointer
// - Page and upper bank come from the last byte loaded
// - Page write or latch reset with empty buffer is an error
// - Buffer writes are ignored while busy
// - Page program erases page first; unloaded bytes become FF
// - Buffer not cleared after write; software resets before loading
// - Keys 53h then A3h reset the buffer from any code area
// - Busy is set while an operation runs, cleared at its end
// - Error flag cleared by software or by a later good sequence
// - Power down discards the buffer and clears the loaded flag
// - Power down while busy waits until the operation ends
// - Loaded flag sets on first byte, clears on good write or reset
module fps_sequencer
    import fps_pkg::*;
#(
    parameter int OP_CYCLES = FPS_OP_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output fps_flash_t flash_q,
    output logic flash_select_q,
    output logic program_busy_flag
);
    initial begin
        if (OP_CYCLES < 1) $error("OP_CYCLES must be at least 1");
    end

    typedef enum logic [1:0] {S_IDLE, S_ERASE, S_PROG, S_WAIT} fps_state_t;

    ////////////////////////////////////////////////////////////////////
    // Bus decode
    wire logic acc = psel && penable && pready;
    wire logic wr = acc && pwrite && pstrb[0];
    wire logic rd = acc && !pwrite;
    wire logic hit_ctrl = paddr == FPS_OFF_CTRL;
    wire logic hit_stat = paddr == FPS_OFF_STAT;
    wire logic hit_bank = paddr == FPS_OFF_BANK;
    wire logic hit_load = paddr == FPS_OFF_LOAD;
    wire logic hit_insn = paddr == FPS_OFF_INSN;
    wire logic hit_page = paddr == FPS_OFF_PAGE;
    wire logic hit_pwr = paddr == FPS_OFF_PWR;
    wire logic hit_any = hit_ctrl | hit_stat | hit_bank | hit_load | hit_insn | hit_page | hit_pwr;
    wire fps_ctrl_t wctrl = fps_ctrl_t'(pwdata[7:0]);

    ////////////////////////////////////////////////////////////////////
    // State
    fps_ctrl_t ctrl_q;
    logic [2:0] bank_q;
    logic armed_q;
    logic seq_err_q;
    logic loaded_q;
    logic pdn_pend_q;
    logic pdn_q;
    logic erased_q;
    logic [15:0] last_addr_q;
    logic [2:0] last_bank_q;
    logic [FPS_PAGE_BYTES-1:0] valid_q;
    fps_state_t state_q;
    fps_op_t op_q;
    logic [15:0] cnt_q;
    logic [FPS_PAGE_AW:0] idx_q;
    logic [7:0] mem_rdata;

    wire logic busy = state_q != S_IDLE;
    // Loads: pointer write with map bit set, ignored while busy
    wire logic load_wr = wr && hit_load && ctrl_q.map && !busy && !pdn_q;
    wire logic [FPS_PAGE_AW-1:0] load_idx = pwdata[8+FPS_PAGE_AW-1:8];
    // Any other instruction cycle reported by the core
    wire logic insn_evt = wr && hit_insn;
    wire logic key_wr = wr && hit_ctrl;
    wire logic key_arm = key_wr && wctrl.key == FPS_KEY_ARM;
    wire logic key_go = key_wr && wctrl.key == FPS_KEY_GO;
    // Second write must be the very next instruction with nibble A
    wire logic seq_bad = armed_q && ((key_wr && !key_go) || insn_evt);
    wire logic seq_ok = armed_q && key_go;
    wire logic needs_data = wctrl.op == FPS_OP_PAGE || wctrl.op == FPS_OP_LRST;
    wire logic empty_err = seq_ok && needs_data && !loaded_q;
    wire logic launch = seq_ok && !empty_err && !busy;
    wire logic is_lrst = wctrl.op == FPS_OP_LRST;
    wire logic start_op = launch && !is_lrst && wctrl.op != FPS_OP_RSV6 && wctrl.op != FPS_OP_RSV7;
    wire logic lrst = launch && is_lrst;
    wire logic [FPS_PAGE_AW-1:0] rd_idx = idx_q[FPS_PAGE_AW-1:0];
    wire logic cnt_done = cnt_q == 16'(OP_CYCLES - 1);
    wire logic byte_last = idx_q == (FPS_PAGE_AW+1)'(FPS_PAGE_BYTES - 1);
    wire logic single = op_q == FPS_OP_SEC || op_q == FPS_OP_FUSE;
    // Security byte may only gain ones after a full erase
    wire logic [7:0] src_byte = valid_q[rd_idx] ? mem_rdata : FPS_ERASED_BYTE;
    wire logic [7:0] prog_byte = (op_q == FPS_OP_SEC && !erased_q) ? (src_byte & flash_q.data) : src_byte;
    wire logic pdn_req = wr && hit_pwr && pwdata[0];
    wire logic pdn_exit = wr && hit_pwr && !pwdata[0];
    wire logic pdn_go = (pdn_req || pdn_pend_q) && !busy;

    fps_latch_mem #(
        .DEPTH(FPS_PAGE_BYTES),
        .AW(FPS_PAGE_AW)
    ) u_mem (
        .pclk(pclk),
        .we(load_wr),
        .waddr(load_idx),
        .wdata(pwdata[31:24]),
        .raddr(rd_idx),
        .rdata(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////
    // Control and key checker
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= fps_ctrl_t'(FPS_CTRL_RST);
            bank_q <= 3'h0;
            armed_q <= 1'b0;
            op_q <= FPS_OP_PAGE;
        end else begin
            if (key_wr) ctrl_q <= wctrl;
            if (wr && hit_bank) bank_q <= pwdata[2:0];
            if (wr) armed_q <= key_arm && !armed_q;
            if (start_op) op_q <= wctrl.op;
        end
    end

    // Error flag: hardware set wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_err_q <= 1'b0;
        end else if (seq_bad || empty_err) begin
            seq_err_q <= 1'b1;
        end else if (seq_ok || (wr && hit_stat && pwdata[FPS_ST_SERR])) begin
            seq_err_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Buffer bookkeeping
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loaded_q <= 1'b0;
            valid_q <= '0;
            last_addr_q <= 16'h0000;
            last_bank_q <= 3'h0;
        end else if (lrst || pdn_go) begin
            loaded_q <= 1'b0;
            valid_q <= '0;
        end else if (load_wr) begin
            loaded_q <= 1'b1;
            valid_q[load_idx] <= 1'b1;
            last_addr_q <= pwdata[23:8];
            last_bank_q <= bank_q;
        end else if (start_op && (wctrl.op == FPS_OP_PAGE || wctrl.op == FPS_OP_XROW)) begin
            loaded_q <= 1'b0;
        end
    end

    // Power down handling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pdn_pend_q <= 1'b0;
            pdn_q <= 1'b0;
            flash_select_q <= 1'b1;
        end else begin
            pdn_pend_q <= (pdn_req || pdn_pend_q) && busy && !pdn_exit;
            if (pdn_go) begin
                pdn_q <= 1'b1;
                flash_select_q <= 1'b0;
            end else if (pdn_exit) begin
                pdn_q <= 1'b0;
                flash_select_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Operation engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
            cnt_q <= 16'h0000;
            idx_q <= '0;
            erased_q <= 1'b0;
            flash_q <= '0;
            program_busy_flag <= 1'b0;
        end else begin
            flash_q.wr <= 1'b0;
            program_busy_flag <= busy || start_op;
            unique case (state_q)
                S_IDLE: begin
                    cnt_q <= 16'h0000;
                    idx_q <= '0;
                    if (start_op) begin
                        flash_q.op <= wctrl.op;
                        flash_q.page <= (wctrl.op == FPS_OP_PAGE) ? last_addr_q[14:7] : 8'h00;
                        flash_q.bank <= last_addr_q[15] ? last_bank_q : 3'h0;
                        state_q <= (wctrl.op == FPS_OP_PAGE || wctrl.op == FPS_OP_XROW || wctrl.op == FPS_OP_ERASE)
                            ? S_ERASE : S_PROG;
                    end
                end
                S_ERASE: begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_done) begin
                        cnt_q <= 16'h0000;
                        if (flash_q.op == FPS_OP_ERASE) begin
                            erased_q <= 1'b1;
                            state_q <= S_WAIT;
                        end else begin
                            state_q <= S_PROG;
                        end
                    end
                end
                S_PROG: begin
                    // One byte per two cycles; memory read is registered
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q[0]) begin
                        flash_q.wr <= 1'b1;
                        flash_q.idx <= rd_idx;
                        flash_q.data <= prog_byte;
                        idx_q <= idx_q + 1'b1;
                        if (byte_last || single) begin
                            cnt_q <= 16'h0000;
                            if (op_q == FPS_OP_SEC) erased_q <= 1'b0;
                            state_q <= S_WAIT;
                        end
                    end
                end
                S_WAIT: begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_done) state_q <= S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB answer
    wire logic [7:0] stat_rd = {4'h0, pdn_q, seq_err_q, loaded_q, busy};
    wire logic [31:0] rd_mux = hit_ctrl ? {24'h00_0000, ctrl_q} :
                               hit_stat ? {24'h00_0000, stat_rd} :
                               hit_bank ? {29'h0000_0000, bank_q} :
                               hit_page ? {13'h0000, last_bank_q, last_addr_q} :
                               hit_pwr ? {31'h0000_0000, pdn_q} : 32'h0000_0000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            prdata <= rd_mux;
            pslverr <= psel && !penable && !hit_any;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    AST_LOAD_IGNORED_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
        (busy && wr && hit_load) |=> $stable(valid_q))
        else $error("Buffer changed while busy");
    AST_EMPTY_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        empty_err |=> seq_err_q && !program_busy_flag)
        else $error("Empty buffer launch not flagged");
    AST_BAD_SEQ: assert property (@(posedge pclk) disable iff (!presetn)
        seq_bad |=> seq_err_q && state_q == $past(state_q))
        else $error("Bad key sequence not flagged");
    AST_BUSY_ON_START: assert property (@(posedge pclk) disable iff (!presetn)
        start_op |=> program_busy_flag ##1 busy)
        else $error("Busy not raised on launch");
    AST_ARM_ONE_CYCLE: assert property (@(posedge pclk) disable iff (!presetn)
        (armed_q && wr) |=> !armed_q)
        else $error("Checker stayed armed");
    AST_LRST_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
        lrst |=> !loaded_q && valid_q == '0)
        else $error("Latch reset did not clear buffer");
    AST_PDN_WAITS: assert property (@(posedge pclk) disable iff (!presetn)
        (busy && !pdn_q) |=> !pdn_q)
        else $error("Power down taken while busy");
    AST_GOOD_CLEARS_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        (seq_ok && !empty_err) |=> !seq_err_q)
        else $error("Good sequence kept error");
    AST_PDN_CLEARS_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        pdn_go |=> !loaded_q && !flash_select_q)
        else $error("Power down kept buffer");
endmodule : fps_sequencer

// ---- verilog/fps_pkg.sv ----
// Package for the flash page program sequencer
package fps_pkg;
    localparam int FPS_PAGE_BYTES = 128;
    localparam int FPS_PAGE_AW = 7;
    // Register byte offsets
    localparam logic [11:0] FPS_OFF_CTRL = 12'h000;
    localparam logic [11:0] FPS_OFF_STAT = 12'h004;
    localparam logic [11:0] FPS_OFF_BANK = 12'h008;
    localparam logic [11:0] FPS_OFF_LOAD = 12'h00C;
    localparam logic [11:0] FPS_OFF_INSN = 12'h010;
    localparam logic [11:0] FPS_OFF_PAGE = 12'h014;
    localparam logic [11:0] FPS_OFF_PWR = 12'h018;
    // Control register fields
    localparam int FPS_KEY_LSB = 4;
    localparam int FPS_MAP_BIT = 3;
    localparam logic [3:0] FPS_KEY_ARM = 4'h5;
    localparam logic [3:0] FPS_KEY_GO = 4'hA;
    localparam logic [7:0] FPS_CTRL_RST = 8'h00;
    // Status register fields
    localparam int FPS_ST_BUSY = 0;
    localparam int FPS_ST_LOAD = 1;
    localparam int FPS_ST_SERR = 2;
    localparam int FPS_ST_PDN = 3;
    localparam logic [7:0] FPS_ERASED_BYTE = 8'hFF;
    // Operation timing
    localparam int FPS_OP_TIME_US = 5;
    localparam int FPS_CLK_MHZ = 125;
    localparam int FPS_OP_CYCLES = FPS_OP_TIME_US * FPS_CLK_MHZ;
    localparam int FPS_BYTE_CYCLES = 2;

    typedef enum logic [2:0] {
        FPS_OP_PAGE,
        FPS_OP_XROW,
        FPS_OP_ERASE,
        FPS_OP_LRST,
        FPS_OP_SEC,
        FPS_OP_FUSE,
        FPS_OP_RSV6,
        FPS_OP_RSV7
    } fps_op_t;

    typedef struct packed {
        logic [3:0] key;
        logic map;
        fps_op_t op;
    } fps_ctrl_t;

    typedef struct packed {
        logic wr;
        logic [7:0] page;
        logic [2:0] bank;
        fps_op_t op;
        logic [FPS_PAGE_AW-1:0] idx;
        logic [7:0] data;
    } fps_flash_t;
endpackage : fps_pkg

// ---- verilog/fps_latch_mem.sv ----
// Column latch memory with registered read
`timescale 1ns/10ps
module fps_latch_mem #(
    parameter int DEPTH = 128,
    parameter int AW = 7
) (
    input wire logic pclk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [DEPTH];
    initial begin
        if (DEPTH != (1 << AW)) $error("DEPTH must be 2**AW");
    end
    always_ff @(posedge pclk) begin
        if (we) mem[waddr] <= wdata;
        rdata <= mem[raddr];
    end
endmodule : fps_latch_mem

// ---- tb/fps_core_model.sv ----
// Core model that runs flash programming software over APB
`timescale 1ns/10ps
module fps_core_model
    import fps_pkg::*;
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic [31:0] rd_q;
    logic err_q;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end

    ////////////////////////////////////////////////////////////////
    // One APB transfer, held until pready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a);
        xfer(1'b0, a, 32'h0000_0000);
    endtask : rd

    ////////////////////////////////////////////////////////////////
    // Byte load through pointer write, map bit set beforehand
    task automatic load(input logic [15:0] ptr, input logic [7:0] d);
        wr(FPS_OFF_LOAD, {d, ptr, 8'h00});
    endtask : load

    // Key pair with nothing in between
    task automatic launch(input logic [2:0] op1, input logic [2:0] op2);
        wr(FPS_OFF_CTRL, {24'h00_0000, FPS_KEY_ARM, 1'b0, op1});
        wr(FPS_OFF_CTRL, {24'h00_0000, FPS_KEY_GO, 1'b0, op2});
    endtask : launch
endmodule : fps_core_model

// ---- tb/testbench.sv ----
// Self-checking bench for the flash page program sequencer
`timescale 1ns/10ps
module testbench
    import fps_pkg::*;
;
    logic pclk;
    logic presetn;
    logic psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic pready, pslverr, flash_select_q, program_busy_flag;
    fps_flash_t flash_q, last_q;
    logic [7:0] img [FPS_PAGE_BYTES];
    int wr_cnt = 0;
    int err_count = 0;
    int check_count = 0;

    fps_sequencer #(.OP_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_q(flash_q), .flash_select_q(flash_select_q),
        .program_busy_flag(program_busy_flag));
    fps_core_model core (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Flash byte capture
    always @(posedge pclk) begin
        if (flash_q.wr === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            img[flash_q.idx] <= flash_q.data;
            last_q <= flash_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic print_verdict();
        if (err_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    task automatic wait_idle();
        int n;
        n = 0;
        do core.rd(FPS_OFF_STAT);
        while (core.rd_q[FPS_ST_BUSY] !== 1'b0 && ++n < 1000);
        if (n >= 1000) err_count++;
    endtask : wait_idle

    ////////////////////////////////////////////////////////////////
    task automatic t_reset_state();
        core.rd(FPS_OFF_STAT);
        chk(core.rd_q, 32'h0000_0000);
        chk(flash_select_q, 1'b1);
        core.rd(12'hFFC);
        chk(core.err_q, 1'b1);
        chk(core.rd_q, 32'h0000_0000);
    endtask : t_reset_state

    task automatic t_bad_seq();
        core.wr(FPS_OFF_CTRL, 32'h0000_0008);
        core.load(16'h0001, 8'h12);
        core.wr(FPS_OFF_CTRL, 32'h0000_0050);
        core.wr(FPS_OFF_INSN, 32'h0000_0000);
        core.wr(FPS_OFF_CTRL, 32'h0000_00A0);
        core.rd(FPS_OFF_STAT);
        chk(core.rd_q[2:0], 3'b110);
        core.wr(FPS_OFF_STAT, 32'h0000_0004);
        core.rd(FPS_OFF_STAT);
        chk(core.rd_q[FPS_ST_SERR], 1'b0);
        core.wr(FPS_OFF_CTRL, 32'h0000_0050);
        core.wr(FPS_OFF_CTRL, 32'h0000_0030);
        core.rd(FPS_OFF_STAT);
        chk(core.rd_q[2:0], 3'b110);
        chk(wr_cnt, 0);
    endtask : t_bad_seq

    task automatic t_latch_reset();
        core.launch(3'd3, 3'd3);
        core.rd(FPS_OFF_STAT);
        chk(core.rd_q[2:0], 3'b000);
        chk(wr_cnt, 0);
    endtask : t_latch_reset

    task automatic t_page();
        core.wr(FPS_OFF_CTRL, 32'h0000_0008);
        core.wr(FPS_OFF_BANK, 32'h0000_0003);
        core.load(16'h0102, 8'h3C);
        core.load(16'h8185, 8'hC3);
        core.wr(FPS_OFF_BANK, 32'h0000_0001);
        core.rd(FPS_OFF_STAT);
        chk(core.rd_q[FPS_ST_LOAD], 1'b1);
        core.launch(3'd2, 3'd0);
        core.rd(FPS_OFF_STAT);
        chk(core.rd_q[FPS_ST_BUSY], 1'b1);
        chk(program_busy_flag, 1'b1);
        core.wr(FPS_OFF_CTRL, 32'h0000_0008);
        core.load(16'h8205, 8'h11);
        core.wr(FPS_OFF_PWR, 32'h0000_0001);
        core.rd(FPS_OFF_STAT);
        chk(core.rd_q[FPS_ST_PDN], 1'b0);
        chk(flash_select_q, 1'b1);
        wait_idle();
        core.rd(FPS_OFF_STAT);
        chk(program_busy_flag, 1'b0);
        chk(flash_select_q, 1'b0);
        chk(core.rd_q[3:0], 4'b1000);
        core.wr(FPS_OFF_PWR, 32'h0000_0000);
        chk(wr_cnt, FPS_PAGE_BYTES);
        for (int i = 0; i < FPS_PAGE_BYTES; i++) begin
            chk(img[i], (i == 2) ? 8'h3C : (i == 5) ? 8'hC3 : FPS_ERASED_BYTE);
        end
        chk({last_q.page, last_q.bank}, {8'h03, 3'd3});
        chk(last_q.op, FPS_OP_PAGE);
    endtask : t_page

    task automatic t_pdn_discard();
        core.wr(FPS_OFF_CTRL, 32'h0000_0008);
        core.load(16'h0010, 8'h44);
        core.wr(FPS_OFF_PWR, 32'h0000_0001);
        core.rd(FPS_OFF_STAT);
        chk(flash_select_q, 1'b0);
        chk(core.rd_q[FPS_ST_LOAD], 1'b0);
        core.wr(FPS_OFF_PWR, 32'h0000_0000);
        core.launch(3'd0, 3'd0);
        core.rd(FPS_OFF_STAT);
        chk(core.rd_q[2:0], 3'b100);
        core.launch(3'd6, 3'd6);
        core.rd(FPS_OFF_STAT);
        chk(core.rd_q[2:0], 3'b000);
        chk(wr_cnt, FPS_PAGE_BYTES);
    endtask : t_pdn_discard

    task automatic one_byte(input logic [31:0] ctrl, input logic [7:0] d, input logic [2:0] op);
        core.wr(FPS_OFF_CTRL, ctrl);
        core.load(16'h0000, d);
        core.launch(op, op);
        wait_idle();
    endtask : one_byte

    task automatic t_erase_sec();
        core.launch(3'd2, 3'd2);
        core.rd(FPS_OFF_STAT);
        chk(core.rd_q[FPS_ST_BUSY], 1'b1);
        wait_idle();
        chk(wr_cnt, FPS_PAGE_BYTES);
        one_byte(32'h0000_000C, 8'hA5, 3'd4);
        chk({last_q.op, last_q.idx, last_q.data}, {FPS_OP_SEC, 7'h00, 8'hA5});
        one_byte(32'h0000_000C, 8'h5A, 3'd4);
        chk(last_q.data, 8'h00);
        one_byte(32'h0000_000D, 8'h77, 3'd5);
        chk({last_q.op, last_q.data}, {FPS_OP_FUSE, 8'h77});
        chk(wr_cnt, FPS_PAGE_BYTES + 3);
    endtask : t_erase_sec

    task automatic t_xrow();
        core.launch(3'd3, 3'd3);
        core.wr(FPS_OFF_CTRL, 32'h0000_0009);
        core.load(16'hFF81, 8'h5E);
        core.launch(3'd1, 3'd1);
        wait_idle();
        chk(core.rd_q[FPS_ST_LOAD], 1'b0);
        chk(wr_cnt, 2 * FPS_PAGE_BYTES + 3);
        chk({img[0], img[1]}, {FPS_ERASED_BYTE, 8'h5E});
        chk(last_q.op, FPS_OP_XROW);
    endtask : t_xrow

    ////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_state();
        t_bad_seq();
        t_latch_reset();
        t_page();
        t_pdn_discard();
        t_erase_sec();
        t_xrow();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        print_verdict();
    end
endmodule : testbench
